// ===== pkg/adc_port_regs.svh
// Constants of the serial command port: command codes, field positions, reset values, timing.
`ifndef ADC_PORT_REGS_SVH
`define ADC_PORT_REGS_SVH
`define CMD_SYNC_FILL 8'hff
`define CMD_SYNC_END 8'hfe
`define CMD_NULL 8'h00
`define CMD_WR_OFFSET 8'h01
`define CMD_WR_GAIN 8'h02
`define CMD_WR_SETUP 8'h03
`define CMD_RD_OFFSET 8'h09
`define CMD_RD_GAIN 8'h0a
`define CMD_RD_SETUP 8'h0b
`define CMD_CAL_OFFSET 8'h85
`define CMD_CAL_GAIN 8'h86
`define CMD_DIR_POS 3
`define CMD_CONV_POS 7
`define CMD_MULTI_POS 6
`define SETUP_PSS_POS 31
`define SETUP_PDW_POS 30
`define SETUP_RS_POS 29
`define SETUP_RV_POS 28
`define SETUP_USED_MASK 32'hfb887e00
`define SETUP_RESET 32'h00000000
`define OFFSET_RESET 32'h00000000
`define GAIN_RESET 32'h01000000
`define SYNC_FILL_MIN 15
`define RESET_HOLD_CYCLES 8
`define OSC_START_MS 20
`define CLK_MHZ 100
`endif

// ===== pkg/adc_port_pkg.sv
// Types shared by the serial command port.
package adc_port_pkg;
    typedef enum logic [1:0] {
        ST_CMD = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ = 2'b10
    } port_state_type;
endpackage

// ===== rtl/adc_serial_command_port.sv
// Serial command port and control logic of the converter.
`timescale 1ns/1ps
`include "adc_port_regs.svh"
// Operation
// R01 - Host performs a software reset first; there is no power-on reset.
// R02 - Fifteen or more fill bytes then one end byte resynchronise into command mode.
// R03 - Resynchronisation is recognised at any moment, even mid-transfer.
// R04 - Reset request resets calibration and internal logic, not the serial port.
// R05 - A completed reset sets the read-only reset-done flag; writes never change it.
// R06 - Host waits eight master clocks, then writes the reset request back to zero.
// R07 - While reset is requested, other setup bits stay zero and ignore writes.
// R08 - Reading the setup word clears the reset-done flag.
// R09 - Reset loads setup zero, offset zero, gain 0x01000000.
// R10 - After reset the port waits in command mode for an 8-bit command.
// R11 - Register commands: upper nibble zero, direction bit 3, low field selects register.
// R12 - Conversion command: bit 7 set, bit 6 chooses single or continuous.
// R13 - 0x85 starts offset calibration, 0x86 starts gain calibration.
// R14 - Null command clears the port flag, keeps continuous conversion.
// R15 - Serial data output is undriven while chip select is high.
// R16 - Serial clock edges are ignored unless chip select is low.
// R17 - Writes take 32 data bits, reads return 32 bits, then command mode.
// R18 - Offset, gain, setup read and write; conversion data is read-only.
// R19 - Setup word is 32 bits, only fifteen carry functions.
// R20 - Power-down stops filtering; choice bit selects standby or sleep.
// R21 - Leaving sleep with a crystal waits about 20 ms before normal operation.
// R22 - The device starts in normal operating mode.
// R23 - Setup bits: choice 31, power-down 30, reset request 29, reset-done 28.
// R24 - Read commands set the direction bit: 0x09, 0x0a, 0x0b.
// R25 - Most significant bit first; sample on rising, update on falling serial clock.
module adc_serial_command_port
    import adc_port_pkg::*;
#(
    parameter int OSC_START_CYCLES = `OSC_START_MS * 1000 * `CLK_MHZ,
    parameter bit CRYSTAL_CLOCK = 1'b1
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Serial link pins.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Conversion data from the filter.
    input wire logic [31:0] conv_data,
    // Dispatched commands and state toward the converter core.
    output logic conv_start,
    output logic multi_conversion_bit,
    output logic cal_offset_start,
    output logic cal_gain_start,
    output logic port_flag_clear,
    output logic core_reset,
    output logic filter_run,
    output logic osc_enable,
    output logic [31:0] setup_word,
    output logic [31:0] offset_word,
    output logic [31:0] gain_word
);
    // Master clocks counted while the reset request stands; the done flag rises one clock after the count.
    localparam int RST_WAIT = `RESET_HOLD_CYCLES;

    // Elaboration check: the wake counter needs a nonzero load, the reset counter four bits.
    if (OSC_START_CYCLES < 1 || RST_WAIT < 1 || RST_WAIT > 15) begin : g_bad_param
        $error("OSC_START_CYCLES or the reset hold count is out of range");
    end

    // Register decode used by both read and write paths.
    function automatic logic [1:0] reg_select(input logic [7:0] cmd);
        reg_select = cmd[1:0];
    endfunction

    // Pin synchronisers: three stages, a change counts once stages two and three agree.
    logic [2:0] cs_sync_ff, sclk_sync_ff, sdi_sync_ff;
    logic [2:0] nxt_cs_sync, nxt_sclk_sync, nxt_sdi_sync;
    logic cs_q_ff, sclk_q_ff, sdi_q_ff, nxt_cs_q, nxt_sclk_q, nxt_sdi_q;
    always_comb begin
        nxt_cs_sync = {cs_sync_ff[1:0], cs_n};
        nxt_sclk_sync = {sclk_sync_ff[1:0], sclk};
        nxt_sdi_sync = {sdi_sync_ff[1:0], sdi};
        nxt_cs_q = (cs_sync_ff[2] == cs_sync_ff[1]) ? cs_sync_ff[2] : cs_q_ff;
        nxt_sclk_q = (sclk_sync_ff[2] == sclk_sync_ff[1]) ? sclk_sync_ff[2] : sclk_q_ff;
        nxt_sdi_q = (sdi_sync_ff[2] == sdi_sync_ff[1]) ? sdi_sync_ff[2] : sdi_q_ff;
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            cs_sync_ff <= 3'h7;
            sclk_sync_ff <= 3'h7; // Idle level of the serial clock, so reset leaves no false edge.
            sdi_sync_ff <= 3'h0;
            cs_q_ff <= 1'b1;
            sclk_q_ff <= 1'b1;
            sdi_q_ff <= 1'b0;
        end else begin
            cs_sync_ff <= nxt_cs_sync;
            sclk_sync_ff <= nxt_sclk_sync;
            sdi_sync_ff <= nxt_sdi_sync;
            cs_q_ff <= nxt_cs_q;
            sclk_q_ff <= nxt_sclk_q;
            sdi_q_ff <= nxt_sdi_q;
        end
    end

    // Edges count only while chip select is already low.
    logic rise, fall;
    assign rise = nxt_sclk_q & ~sclk_q_ff & ~cs_q_ff; // R16 R25
    assign fall = ~nxt_sclk_q & sclk_q_ff & ~cs_q_ff; // R16 R25

    // Serial port state: shifter, bit count, command, resync detector, register file.
    port_state_type state_ff, nxt_state;
    logic [31:0] shift_ff, nxt_shift;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [7:0] win_ff, nxt_win;
    logic [4:0] fill_ff, nxt_fill;
    logic [2:0] fill_bits_ff, nxt_fill_bits;
    logic [31:0] out_ff, nxt_out;
    logic sdo_ff, nxt_sdo;
    logic [31:0] setup_ff, nxt_setup, offset_ff, nxt_offset, gain_ff, nxt_gain;
    logic rv_ff, nxt_rv;
    logic [3:0] rst_cnt_ff, nxt_rst_cnt;
    logic conv_ff, nxt_conv, multi_ff, nxt_multi, calo_ff, nxt_calo, calg_ff, nxt_calg;
    logic null_ff, nxt_null;
    logic [7:0] win_next;
    logic [31:0] shift_in;
    logic [31:0] wdata;

    always_comb begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_cmd = cmd_ff;
        nxt_win = win_ff;
        nxt_fill = fill_ff;
        nxt_fill_bits = fill_bits_ff;
        nxt_out = out_ff;
        nxt_sdo = sdo_ff;
        nxt_setup = setup_ff;
        nxt_offset = offset_ff;
        nxt_gain = gain_ff;
        nxt_rv = rv_ff;
        nxt_rst_cnt = rst_cnt_ff;
        nxt_conv = 1'b0;
        nxt_multi = multi_ff;
        nxt_calo = 1'b0;
        nxt_calg = 1'b0;
        nxt_null = 1'b0;
        win_next = {win_ff[6:0], nxt_sdi_q};
        shift_in = {shift_ff[30:0], nxt_sdi_q};
        wdata = shift_in;
        if (rise) begin
            // Resync detector runs on a free byte window, independent of the port state.
            nxt_win = win_next; // R03
            nxt_fill_bits = fill_bits_ff + 3'h1;
            if (win_next == `CMD_SYNC_END && fill_ff >= 5'(`SYNC_FILL_MIN)) begin
                nxt_state = ST_CMD; // R02 R03
                nxt_cnt = 6'h0;
                nxt_fill = 5'h0;
                nxt_fill_bits = 3'h0;
            end else if (fill_bits_ff == 3'h7) begin
                if (win_next == `CMD_SYNC_FILL) begin
                    nxt_fill = (fill_ff == 5'h1f) ? fill_ff : fill_ff + 5'h1;
                end else begin
                    nxt_fill = 5'h0;
                end
            end
            if (!(win_next == `CMD_SYNC_END && fill_ff >= 5'(`SYNC_FILL_MIN))) begin
                nxt_shift = shift_in; // R25
                nxt_cnt = cnt_ff + 6'h1;
                case (state_ff)
                    ST_CMD: begin
                        if (cnt_ff == 6'd7) begin // R10
                            nxt_cnt = 6'h0;
                            nxt_cmd = shift_in[7:0];
                            if (shift_in[7:4] == 4'h0 && shift_in[2:0] != 3'h0
                                && reg_select(shift_in[7:0]) != 2'h0 && !shift_in[2]) begin
                                // R11 R24
                                if (shift_in[`CMD_DIR_POS]) begin
                                    nxt_state = ST_READ;
                                    case (reg_select(shift_in[7:0]))
                                        2'h1: nxt_out = offset_ff;
                                        2'h2: nxt_out = gain_ff;
                                        default: begin
                                            nxt_out = setup_ff;
                                            nxt_out[`SETUP_RV_POS] = rv_ff;
                                            nxt_rv = 1'b0; // R08
                                        end
                                    endcase
                                end else begin
                                    nxt_state = ST_WRITE;
                                end
                            end else if (shift_in[7:0] == `CMD_NULL) begin
                                nxt_null = 1'b1; // R14
                                nxt_multi = 1'b1;
                            end else if (shift_in[7:0] == `CMD_CAL_OFFSET) begin
                                nxt_calo = 1'b1; // R13
                            end else if (shift_in[7:0] == `CMD_CAL_GAIN) begin
                                nxt_calg = 1'b1; // R13
                            end else if (shift_in[`CMD_CONV_POS] && shift_in[5:0] == 6'h0) begin
                                nxt_conv = 1'b1; // R12
                                nxt_multi = shift_in[`CMD_MULTI_POS];
                                nxt_state = ST_READ; // Result word is then clocked out.
                                nxt_out = conv_data; // R18
                            end
                        end
                    end
                    ST_WRITE: begin
                        if (cnt_ff == 6'd31) begin // R17
                            nxt_cnt = 6'h0;
                            nxt_state = ST_CMD;
                            case (reg_select(cmd_ff))
                                2'h1: nxt_offset = wdata;
                                2'h2: nxt_gain = wdata;
                                default: begin
                                    // Only functional bits stick; the flag is hardware-owned.
                                    if (setup_ff[`SETUP_RS_POS] || wdata[`SETUP_RS_POS]) begin
                                        nxt_setup = '0; // R07 R09
                                        nxt_setup[`SETUP_RS_POS] = wdata[`SETUP_RS_POS];
                                    end else begin
                                        nxt_setup = wdata & `SETUP_USED_MASK; // R19 R23
                                    end
                                    nxt_setup[`SETUP_RV_POS] = 1'b0; // R05
                                end
                            endcase
                        end
                    end
                    ST_READ: begin
                        if (cnt_ff == 6'd31) begin // R17
                            nxt_cnt = 6'h0;
                            nxt_state = ST_CMD;
                        end
                    end
                    default: begin
                        nxt_state = ST_CMD;
                    end
                endcase
            end
        end
        // Output bit moves on the falling edge, MSB first.
        if (fall && state_ff == ST_READ) begin
            nxt_sdo = out_ff[31]; // R25
            nxt_out = {out_ff[30:0], 1'b0};
        end
        if (state_ff != ST_READ) begin
            nxt_sdo = 1'b0;
        end
        // Reset request held: count master clocks, then flag a completed reset.
        // Placed last so the flag's set beats a read's clear and the hold beats a write.
        if (setup_ff[`SETUP_RS_POS]) begin
            if (rst_cnt_ff != 4'(RST_WAIT)) begin
                nxt_rst_cnt = rst_cnt_ff + 4'h1;
            end else if (!rv_ff && rst_cnt_ff == 4'(RST_WAIT)) begin
                nxt_rv = 1'b1; // R05
                nxt_rst_cnt = rst_cnt_ff;
            end
            nxt_offset = `OFFSET_RESET; // R04 R09
            nxt_gain = `GAIN_RESET; // R09
        end else begin
            nxt_rst_cnt = 4'h0;
        end
    end

    // Port state is left alone by the reset request; only srst clears it.
    always_ff @(posedge clock) begin
        if (srst) begin
            state_ff <= ST_CMD;
            shift_ff <= '0;
            cnt_ff <= 6'h0;
            cmd_ff <= 8'h00;
            win_ff <= 8'h00;
            fill_ff <= 5'h0;
            fill_bits_ff <= 3'h0;
            out_ff <= '0;
            sdo_ff <= 1'b0;
            setup_ff <= `SETUP_RESET;
            offset_ff <= `OFFSET_RESET;
            gain_ff <= `GAIN_RESET;
            rv_ff <= 1'b0;
            rst_cnt_ff <= 4'h0;
            conv_ff <= 1'b0;
            multi_ff <= 1'b0;
            calo_ff <= 1'b0;
            calg_ff <= 1'b0;
            null_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state; // R04
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            cmd_ff <= nxt_cmd;
            win_ff <= nxt_win;
            fill_ff <= nxt_fill;
            fill_bits_ff <= nxt_fill_bits;
            out_ff <= nxt_out;
            sdo_ff <= nxt_sdo;
            setup_ff <= nxt_setup;
            offset_ff <= nxt_offset;
            gain_ff <= nxt_gain;
            rv_ff <= nxt_rv;
            rst_cnt_ff <= nxt_rst_cnt;
            conv_ff <= nxt_conv;
            multi_ff <= nxt_multi;
            calo_ff <= nxt_calo;
            calg_ff <= nxt_calg;
            null_ff <= nxt_null;
        end
    end

    // Power control: sleep stops the oscillator, waking waits for start-up on a crystal.
    logic sleep_ff, nxt_sleep;
    logic [31:0] wake_ff, nxt_wake;
    logic power_down_bit, power_save_choice_bit;
    assign power_down_bit = setup_ff[`SETUP_PDW_POS];
    assign power_save_choice_bit = setup_ff[`SETUP_PSS_POS];
    always_comb begin
        nxt_sleep = power_down_bit & power_save_choice_bit; // R20
        nxt_wake = wake_ff;
        if (sleep_ff && !(power_down_bit && power_save_choice_bit) && CRYSTAL_CLOCK) begin
            nxt_wake = 32'(OSC_START_CYCLES); // R21
        end else if (wake_ff != 32'h0) begin
            nxt_wake = wake_ff - 32'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            sleep_ff <= 1'b0; // R22
            wake_ff <= 32'h0;
        end else begin
            sleep_ff <= nxt_sleep;
            wake_ff <= nxt_wake;
        end
    end

    // Outputs; a plain data pin is released whenever chip select is high.
    assign sdo = sdo_ff;
    assign sdo_oe = ~cs_q_ff & (state_ff == ST_READ); // R15
    assign conv_start = conv_ff;
    assign multi_conversion_bit = multi_ff;
    assign cal_offset_start = calo_ff;
    assign cal_gain_start = calg_ff;
    assign port_flag_clear = null_ff;
    assign core_reset = setup_ff[`SETUP_RS_POS]; // R04
    assign filter_run = ~power_down_bit & ~sleep_ff & (wake_ff == 32'h0); // R20 R21
    assign osc_enable = ~(power_down_bit & power_save_choice_bit); // R20
    assign setup_word = {setup_ff[31:29], rv_ff, setup_ff[27:0]};
    assign offset_word = offset_ff;
    assign gain_word = gain_ff;
endmodule

// ===== bench/adc_serial_command_port_monitor.sv
// Concurrent checks on the ports of the serial command port.
`timescale 1ns/1ps
module adc_serial_command_port_monitor #(
    parameter int OSC_START_CYCLES = 50,
    parameter bit CRYSTAL_CLOCK = 1'b1
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Serial link pins.
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    // Core side.
    input wire logic [31:0] conv_data,
    input wire logic conv_start,
    input wire logic multi_conversion_bit,
    input wire logic cal_offset_start,
    input wire logic cal_gain_start,
    input wire logic port_flag_clear,
    input wire logic core_reset,
    input wire logic filter_run,
    input wire logic osc_enable,
    input wire logic [31:0] setup_word,
    input wire logic [31:0] offset_word,
    input wire logic [31:0] gain_word
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // The synchroniser needs four clocks before a raised select is seen.
    property p_sdo_idle;
        cs_n [*5] |-> !sdo_oe;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while deselected");
    property p_reset_values;
        @(posedge clock) disable iff (1'b0)
        srst |=> setup_word == 32'h00000000 && offset_word == 32'h00000000
            && gain_word == 32'h01000000;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values");
    property p_normal_start;
        @(posedge clock) disable iff (1'b0) srst |=> filter_run && osc_enable && !conv_start;
    endproperty
    a_normal_start: assert property (p_normal_start) else $error("not normal after reset");
    property p_hold_setup;
        core_reset |-> (setup_word & 32'hcfffffff) == 32'h00000000;
    endproperty
    a_hold_setup: assert property (p_hold_setup) else $error("setup bits set in reset");
    property p_hold_cal;
        core_reset && $past(core_reset) |-> offset_word == 32'h00000000
            && gain_word == 32'h01000000;
    endproperty
    a_hold_cal: assert property (p_hold_cal) else $error("calibration not reset");
    property p_done_flag;
        $rose(core_reset) |-> ##[1:10] setup_word[28];
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("reset-done flag not set");
    property p_pulses;
        $onehot0({conv_start, cal_offset_start, cal_gain_start, port_flag_clear})
            and (conv_start |=> !conv_start);
    endproperty
    a_pulses: assert property (p_pulses) else $error("command pulses overlap");
    property p_null_multi;
        port_flag_clear |=> multi_conversion_bit;
    endproperty
    a_null_multi: assert property (p_null_multi) else $error("null left single mode");
    property p_power_down;
        setup_word[30] && $past(setup_word[30]) |-> !filter_run
            && (osc_enable == !setup_word[31]);
    endproperty
    a_power_down: assert property (p_power_down) else $error("power save state wrong");
    property p_wake_wait;
        CRYSTAL_CLOCK && $fell(setup_word[30]) && $past(setup_word[31]) |-> !filter_run [*8];
    endproperty
    a_wake_wait: assert property (p_wake_wait) else $error("no oscillator wait");
    c_conv: cover property (conv_start);
    c_sleep: cover property (!osc_enable);
    c_reset: cover property ($rose(setup_word[28]));
endmodule
bind adc_serial_command_port adc_serial_command_port_monitor #(
    .OSC_START_CYCLES(OSC_START_CYCLES), .CRYSTAL_CLOCK(CRYSTAL_CLOCK)
) adc_serial_command_port_monitor_inst (.*);

// ===== bench/host_link_model.sv
// Host microcontroller model that drives the serial link of the converter.
`timescale 1ns/1ps
module host_link_model (
    // Clock.
    input wire logic clock,
    // Serial link pins.
    output logic cs_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // Serial clock stands high between frames.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        sdi = 1'b0;
    end
    // One 160 ns bit: data moves with the fall, both sides sample at the rise.
    task automatic bit_xfer(input logic b, input logic sel_n, output logic q);
        cs_n <= sel_n;
        sdi <= b;
        sclk <= 1'b0;
        repeat (8) @(posedge clock);
        sclk <= 1'b1;
        // A released line reads as the inverse, so a read while undriven shows up.
        q = sdo_oe ? sdo : ~sdo;
        repeat (8) @(posedge clock);
    endtask
    // Select is lowered well before the first edge so no edge is lost.
    task automatic select(input logic sel_n);
        cs_n <= sel_n;
        repeat (6) @(posedge clock);
    endtask
    // Command byte, most significant bit first.
    task automatic send(input logic [7:0] b, input logic sel_n);
        logic q;
        for (int i = 7; i >= 0; i--) bit_xfer(b[i], sel_n, q);
    endtask
    // A 32-bit data word, written and read at once.
    task automatic word(input logic [31:0] d, output logic [31:0] q);
        for (int i = 31; i >= 0; i--) bit_xfer(d[i], 1'b0, q[i]);
    endtask
endmodule

// ===== bench/adc_serial_command_port_bench.sv
// Self-checking bench of the serial command port.
`timescale 1ns/1ps
`include "adc_port_regs.svh"
module adc_serial_command_port_bench;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [31:0] conv_data = 32'h00000000;
    logic cs_n, sclk, sdi, sdo, sdo_oe, conv_start, multi_conversion_bit, core_reset;
    logic cal_offset_start, cal_gain_start, port_flag_clear, filter_run, osc_enable;
    logic [31:0] setup_word, offset_word, gain_word, q, d, exp_reg[3];
    int fail_count = 0;
    int total_checks = 0;
    int n_pulse[4] = '{0, 0, 0, 0};
    int e_pulse[4];
    int n;
    logic [7:0] ops[5] = '{8'h80, 8'hc0, 8'h85, 8'h86, 8'h00};
    // Wake wait is shortened so that the run stays brief.
    adc_serial_command_port #(.OSC_START_CYCLES(50), .CRYSTAL_CLOCK(1'b1))
        adc_serial_command_port_inst (.*);
    host_link_model host_link_model_inst (.*);
    initial forever #5 clock = ~clock;
    // Pulse counters let each command be judged by what it dispatched.
    always @(posedge clock) begin
        n_pulse[0] += int'(conv_start);
        n_pulse[1] += int'(cal_offset_start);
        n_pulse[2] += int'(cal_gain_start);
        n_pulse[3] += int'(port_flag_clear);
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] c, input logic [31:0] w);
        host_link_model_inst.send(c, 1'b0);
        host_link_model_inst.word(w, q);
        repeat (4) @(posedge clock);
    endtask
    task automatic resync();
        for (int i = 0; i < 15; i++) host_link_model_inst.send(`CMD_SYNC_FILL, 1'b0);
        host_link_model_inst.send(`CMD_SYNC_END, 1'b0);
    endtask
    initial begin
        void'($urandom(52561));
        exp_reg = '{32'h00000000, 32'h01000000, 32'h00000000};
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        repeat (6) @(posedge clock);
        check("gain", gain_word, `GAIN_RESET);
        check("run", {filter_run, osc_enable}, 32'h3);
        host_link_model_inst.select(1'b0);
        resync();
        d = $urandom;
        xfer(`CMD_WR_OFFSET, d);
        check("offset", offset_word, d);
        xfer(`CMD_WR_SETUP, $urandom | 32'h20000000);
        repeat (12) @(posedge clock);
        check("setup held", setup_word, 32'h30000000);
        check("core reset", core_reset, 1'b1);
        check("offset", offset_word, `OFFSET_RESET);
        xfer(`CMD_WR_SETUP, 32'h10000000);
        check("flag kept", setup_word, 32'h10000000);
        xfer(`CMD_RD_SETUP, 32'h00000000);
        check("flag read", q, 32'h10000000);
        check("flag cleared", setup_word, 32'h00000000);
        for (int i = 0; i < 9; i++) begin
            n = (i < 3) ? i : int'($urandom_range(2));
            d = $urandom & ((n == 2) ? 32'h0fffffff : 32'hffffffff);
            exp_reg[n] = (n == 2) ? (d & `SETUP_USED_MASK) : d;
            xfer(8'h01 + 8'(n), d);
            host_link_model_inst.send(8'h55, 1'b0);
            xfer(8'h09 + 8'(n), ~d);
            check("read back", q, exp_reg[n]);
        end
        check("setup", setup_word, exp_reg[2]);
        foreach (ops[k]) begin
            e_pulse = n_pulse;
            conv_data <= $urandom;
            host_link_model_inst.send(ops[k], 1'b0);
            // Only the conversion commands are followed by a result word.
            if (k < 2) begin
                host_link_model_inst.word(32'h0, q);
                check("conv data", q, conv_data);
            end
            repeat (4) @(posedge clock);
            e_pulse[(k < 2) ? 0 : k - 1]++;
            for (int j = 0; j < 4; j++) check("pulses", n_pulse[j], e_pulse[j]);
            if (k != 2 && k != 3) check("multi", multi_conversion_bit, k != 0);
        end
        host_link_model_inst.send(`CMD_RD_OFFSET, 1'b0);
        for (int i = 0; i < 5; i++) resync();
        xfer(`CMD_RD_GAIN, 32'h0);
        check("gain after resync", q, exp_reg[1]);
        // Deselect after the read command, before its data word: the pin is released and edges are ignored until reselected.
        host_link_model_inst.send(`CMD_RD_GAIN, 1'b0);
        check("sdo on", sdo_oe, 1'b1);
        host_link_model_inst.select(1'b1);
        check("sdo off", sdo_oe, 1'b0);
        e_pulse = n_pulse;
        host_link_model_inst.send(8'h00, 1'b1);
        check("ignored", n_pulse[3], e_pulse[3]);
        host_link_model_inst.select(1'b0);
        host_link_model_inst.word(32'h0, q);
        check("read resumed", q, exp_reg[1]);
        xfer(`CMD_WR_SETUP, 32'h40000000);
        check("standby", {filter_run, osc_enable}, 32'h1);
        xfer(`CMD_WR_SETUP, 32'hc0000000);
        check("sleep", {filter_run, osc_enable}, 32'h0);
        host_link_model_inst.send(`CMD_WR_SETUP, 1'b0);
        host_link_model_inst.word(32'h0, q);
        n = 0;
        // The wake counter of 50 clocks starts a few clocks before the word task returns.
        while (filter_run !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        check("wake wait", 32'(n >= 45 && n <= 50), 32'h1);
        end_of_test();
    end
endmodule
